// *** logic/scan_unit.sv ***
// Behaviour
// - Test logic follows the standard four-wire test access port behaviour.
// - I/O-standard instruction may update pin standards before or in user mode.
// - PLL reconfiguration bits sit in the chain only until configured.
// - Code 005 samples pins and preloads the boundary register.
// - Code 000 drives boundary values out and captures input pins.
// - All-ones code puts one-bit bypass in path, pins stay normal.
// - Code 007 shifts the 32-bit user code out.
// - Code 006 shifts the identification value out.
// - Code 00B selects bypass and floats every I/O pin.
// - Code 00A selects bypass and holds pins from boundary register.
// - Code 001 requests reconfiguration like a restart pin low pulse.
// - Code 00D accepted anytime; it aborts configuration in progress.
// - After code 00D the status pin is held low until reconfigured.
// - Instruction register is 10 bits, user code 32 bits.
// - Identification is version, part, maker fields and a one.
// - Bus hold or pull-up overrides forced high impedance.
`timescale 1ns/10ps
`default_nettype none
module scan_unit
	import scan_pkg::*;
#(
	parameter int NPINS = 8,
	parameter int NPLL = 4,
	parameter logic [USER_LEN-1:0] USER_CODE = 32'hFFFFFFFF
)(
	input wire logic clk_sys,
	input wire logic resetn,
	input wire tap_pins_s tap_in,
	input wire logic trst_n,
	output logic tdo_r,
	output logic tdo_oe_r,
	input wire logic [NPINS-1:0] pin_in,
	input wire logic [NPINS-1:0] core_out,
	input wire logic [NPINS-1:0] core_oe,
	input wire logic [NPINS-1:0] keeper_en,
	output logic [NPINS-1:0] pin_out_r,
	output logic [NPINS-1:0] pin_oe_r,
	output logic [NPINS-1:0] pin_keep_r,
	input wire logic configured,
	input wire logic configuring,
	output logic config_restart_r,
	output logic config_abort_r,
	output logic config_status_oe_r,
	output logic iostd_load_r,
	output logic [NPINS-1:0] iostd_r,
	output logic [NPLL-1:0] pll_bits_r
);
	localparam int BSR_LEN = 3 * NPINS;

	// =====================================================================
	// Pin synchronisers: every test pin passes two flops before use.
	tap_pins_s sync1_r, sync2_r;
	logic trst1_r, trst2_r, tck_d_r;
	logic [NPINS-1:0] pin1_r, pin2_r;
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			sync1_r <= '0;
			sync2_r <= '0;
			trst1_r <= 1'b0;
			trst2_r <= 1'b0;
			tck_d_r <= 1'b0;
			pin1_r <= '0;
			pin2_r <= '0;
		end else begin
			sync1_r <= tap_in;
			sync2_r <= sync1_r;
			trst1_r <= trst_n;
			trst2_r <= trst1_r;
			tck_d_r <= sync2_r.tck;
			pin1_r <= pin_in;
			pin2_r <= pin1_r;
		end
	end
	wire logic tck_rise = sync2_r.tck && !tck_d_r;
	wire logic tck_fall = !sync2_r.tck && tck_d_r;

	// =====================================================================
	// Controller.
	tap_state_e state_r;
	tap_ctl_s ctl;
	tap_fsm u_fsm (
		.clk_sys(clk_sys),
		.resetn(resetn),
		.tck_rise(tck_rise),
		.tms(sync2_r.tms),
		.state_r(state_r),
		.ctl(ctl)
	);
	wire logic in_reset = state_r == TRESET || !trst2_r;

	// =====================================================================
	// Instruction register, 10 bits.
	logic [IR_LEN-1:0] ir_sh_r, ir_r;
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			ir_sh_r <= '0;
		end else if (ctl.ir_capture) begin
			ir_sh_r <= IR_CAPTURE;
		end else if (ctl.ir_shift) begin
			ir_sh_r <= {sync2_r.tdi, ir_sh_r[IR_LEN-1:1]};
		end
	end
	// Reset state loads the identification instruction.
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			ir_r <= OP_IDENT;
		end else if (in_reset) begin
			ir_r <= OP_IDENT;
		end else if (ctl.ir_update) begin
			ir_r <= ir_sh_r;
		end
	end

	// =====================================================================
	// Decode; unknown codes fall back to bypass with normal pins.
	function automatic dr_sel_e decode_sel(input logic [IR_LEN-1:0] op);
		unique case (op)
			OP_EXTEST, OP_SAMPLE: decode_sel = SEL_BSR;
			// New pin standards arrive serially through the boundary cells.
			OP_IOSTD: decode_sel = SEL_BSR;
			OP_IDENT: decode_sel = SEL_IDC;
			OP_USER: decode_sel = SEL_USR;
			default: decode_sel = SEL_BYP;
		endcase
	endfunction
	dr_sel_e sel;
	assign sel = decode_sel(ir_r);
	wire logic test_drive = ir_r == OP_EXTEST || ir_r == OP_CLAMP;
	wire logic test_float = ir_r == OP_HIGHZ;
	// PLL bits join the boundary chain only while unconfigured.
	wire logic pll_in_chain = !configured;

	// =====================================================================
	// Data registers.
	localparam logic [ID_LEN-1:0] ID_VALUE = {ID_VERSION, ID_PART, ID_MAKER,
		ID_LSB};
	logic byp_r;
	logic [ID_LEN-1:0] id_sh_r;
	logic [USER_LEN-1:0] usr_sh_r;
	logic [BSR_LEN-1:0] bsr_sh_r, bsr_up_r;
	logic [NPLL-1:0] pll_sh_r;
	wire logic bsr_tail = pll_in_chain ? pll_sh_r[0] : bsr_sh_r[0];
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			byp_r <= 1'b0;
			id_sh_r <= '0;
			usr_sh_r <= '0;
		end else if (ctl.capture) begin
			byp_r <= 1'b0;
			id_sh_r <= ID_VALUE;
			usr_sh_r <= USER_CODE;
		end else if (ctl.shift) begin
			byp_r <= sync2_r.tdi;
			id_sh_r <= {sync2_r.tdi, id_sh_r[ID_LEN-1:1]};
			usr_sh_r <= {sync2_r.tdi, usr_sh_r[USER_LEN-1:1]};
		end
	end
	// Boundary cells: per pin, input, output value, output enable.
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			bsr_sh_r <= '0;
			pll_sh_r <= '0;
		end else if (ctl.capture && sel == SEL_BSR) begin
			bsr_sh_r <= {pin2_r, core_out, core_oe};
		end else if (ctl.shift && sel == SEL_BSR) begin
			if (pll_in_chain) begin
				pll_sh_r <= {bsr_sh_r[0], pll_sh_r[NPLL-1:1]};
			end
			bsr_sh_r <= {sync2_r.tdi, bsr_sh_r[BSR_LEN-1:1]};
		end
	end
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			bsr_up_r <= '0;
			pll_bits_r <= '0;
		end else if (ctl.update && sel == SEL_BSR) begin
			bsr_up_r <= bsr_sh_r;
			if (pll_in_chain) begin
				pll_bits_r <= pll_sh_r;
			end
		end
	end

	// =====================================================================
	// Serial output changes on the falling test clock edge.
	logic tdo_bit;
	always_comb begin
		unique case (sel)
			SEL_IDC: tdo_bit = id_sh_r[0];
			SEL_USR: tdo_bit = usr_sh_r[0];
			SEL_BSR: tdo_bit = bsr_tail;
			default: tdo_bit = byp_r;
		endcase
	end
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			tdo_r <= 1'b0;
			tdo_oe_r <= 1'b0;
		end else if (tck_fall) begin
			tdo_r <= (state_r == SH_IR) ? ir_sh_r[0] : tdo_bit;
			tdo_oe_r <= state_r == SH_IR || state_r == SH_DR;
		end
	end

	// =====================================================================
	// Pin control.
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			pin_out_r <= '0;
			pin_oe_r <= '0;
			pin_keep_r <= '0;
		end else if (test_float) begin
			pin_out_r <= '0;
			pin_oe_r <= '0;
			pin_keep_r <= keeper_en;
		end else if (test_drive) begin
			pin_out_r <= bsr_up_r[2*NPINS-1:NPINS];
			pin_oe_r <= bsr_up_r[NPINS-1:0];
			pin_keep_r <= keeper_en & ~bsr_up_r[NPINS-1:0];
		end else begin
			pin_out_r <= core_out;
			pin_oe_r <= core_oe;
			pin_keep_r <= keeper_en;
		end
	end

	// =====================================================================
	// Configuration side effects, acting on instruction update or, for pin standards, data update.
	wire logic upd_restart = ctl.ir_update && ir_sh_r == OP_RESTART;
	wire logic upd_iostd = ctl.ir_update && ir_sh_r == OP_IOSTD;
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			config_restart_r <= 1'b0;
			config_abort_r <= 1'b0;
		end else begin
			config_restart_r <= upd_restart;
			config_abort_r <= upd_iostd && configuring;
		end
	end
	// Held until the configured flag rises again; a new issue wins.
	logic configured_d_r;
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			config_status_oe_r <= 1'b0;
			configured_d_r <= 1'b0;
		end else begin
			configured_d_r <= configured;
			if (upd_iostd) begin
				config_status_oe_r <= 1'b1;
			end else if (configured && !configured_d_r) begin
				config_status_oe_r <= 1'b0;
			end
		end
	end
	// Pin standards load from the boundary cells while in that instruction.
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			iostd_r <= '0;
			iostd_load_r <= 1'b0;
		end else begin
			iostd_load_r <= ctl.update && ir_r == OP_IOSTD;
			if (ctl.update && ir_r == OP_IOSTD) begin
				iostd_r <= bsr_sh_r[NPINS-1:0];
			end
		end
	end

	// =====================================================================
	// Checks.
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn);

	a_bypass_unknown: assert property (
		(ir_r != OP_EXTEST && ir_r != OP_SAMPLE && ir_r != OP_IDENT &&
		ir_r != OP_USER && ir_r != OP_IOSTD) |-> sel == SEL_BYP)
		else $error("unknown code not in bypass");
	a_highz_float: assert property (
		test_float |=> pin_oe_r == '0)
		else $error("pins driven in highz");
	a_bypass_pins: assert property (
		ir_r == OP_BYPASS |=> pin_oe_r == $past(core_oe))
		else $error("bypass disturbs pins");
	sequence s_restart_once;
		config_restart_r ##1 !config_restart_r;
	endsequence
	a_restart_pulse: assert property (
		upd_restart |=> s_restart_once)
		else $error("restart not a single pulse");
	a_iostd_status: assert property (
		upd_iostd |=> config_status_oe_r)
		else $error("status not held low");
	a_status_hold: assert property (
		config_status_oe_r && !(configured && !configured_d_r) |=>
		config_status_oe_r)
		else $error("status released early");
	a_abort_cfg: assert property (
		upd_iostd && configuring |=> config_abort_r)
		else $error("abort missing");
	a_ident_load: assert property (
		ctl.capture |=> id_sh_r == ID_VALUE && id_sh_r[0])
		else $error("ident capture wrong");
	a_trst_ident: assert property (
		!trst2_r |=> ir_r == OP_IDENT)
		else $error("reset did not load ident");
	a_pll_frozen: assert property (
		configured && $stable(configured) |=> $stable(pll_bits_r))
		else $error("pll bits changed after config");
endmodule
`default_nettype wire

// *** logic/scan_pkg.sv ***
package scan_pkg;
	localparam int IR_LEN = 10;
	localparam int USER_LEN = 32;
	localparam int ID_LEN = 32;
	localparam logic [9:0] OP_EXTEST = 10'h000;
	localparam logic [9:0] OP_RESTART = 10'h001;
	localparam logic [9:0] OP_SAMPLE = 10'h005;
	localparam logic [9:0] OP_IDENT = 10'h006;
	localparam logic [9:0] OP_USER = 10'h007;
	localparam logic [9:0] OP_CLAMP = 10'h00A;
	localparam logic [9:0] OP_HIGHZ = 10'h00B;
	localparam logic [9:0] OP_IOSTD = 10'h00D;
	localparam logic [9:0] OP_BYPASS = 10'h3FF;
	// Capture pattern of the instruction register: low two bits 01.
	localparam logic [9:0] IR_CAPTURE = 10'h001;
	localparam logic [3:0] ID_VERSION = 4'h0;
	// Part and maker fields are arbitrary values.
	localparam logic [15:0] ID_PART = 16'h0001;
	localparam logic [10:0] ID_MAKER = 11'h001;
	localparam logic ID_LSB = 1'b1;
	localparam int TCK_PERIOD_NS = 64;
	localparam int CLK_NS = 4;
	localparam int TCK_CYCLES = (TCK_PERIOD_NS + CLK_NS - 1) / CLK_NS;
	typedef enum logic [3:0] {
		TRESET, IDLE, SEL_DR, CAP_DR, SH_DR, EX1_DR, PAU_DR, EX2_DR, UPD_DR,
		SEL_IR, CAP_IR, SH_IR, EX1_IR, PAU_IR, EX2_IR, UPD_IR
	} tap_state_e;
	typedef enum logic [2:0] {
		SEL_BYP, SEL_IDC, SEL_USR, SEL_BSR
	} dr_sel_e;
	typedef struct packed {
		logic tck;
		logic tms;
		logic tdi;
	} tap_pins_s;
	typedef struct packed {
		logic capture;
		logic shift;
		logic update;
		logic ir_capture;
		logic ir_shift;
		logic ir_update;
	} tap_ctl_s;
endpackage

// *** logic/tap_fsm.sv ***
`timescale 1ns/10ps
`default_nettype none
module tap_fsm
	import scan_pkg::*;
(
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic tck_rise,
	input wire logic tms,
	output tap_state_e state_r,
	output tap_ctl_s ctl
);
	tap_state_e state_nxt;

	// =====================================================================
	// Standard sixteen-state controller, stepped on each test clock rise.
	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			TRESET: state_nxt = tms ? TRESET : IDLE;
			IDLE: state_nxt = tms ? SEL_DR : IDLE;
			SEL_DR: state_nxt = tms ? SEL_IR : CAP_DR;
			CAP_DR: state_nxt = tms ? EX1_DR : SH_DR;
			SH_DR: state_nxt = tms ? EX1_DR : SH_DR;
			EX1_DR: state_nxt = tms ? UPD_DR : PAU_DR;
			PAU_DR: state_nxt = tms ? EX2_DR : PAU_DR;
			EX2_DR: state_nxt = tms ? UPD_DR : SH_DR;
			UPD_DR: state_nxt = tms ? SEL_DR : IDLE;
			SEL_IR: state_nxt = tms ? TRESET : CAP_IR;
			CAP_IR: state_nxt = tms ? EX1_IR : SH_IR;
			SH_IR: state_nxt = tms ? EX1_IR : SH_IR;
			EX1_IR: state_nxt = tms ? UPD_IR : PAU_IR;
			PAU_IR: state_nxt = tms ? EX2_IR : PAU_IR;
			EX2_IR: state_nxt = tms ? UPD_IR : SH_IR;
			UPD_IR: state_nxt = tms ? SEL_DR : IDLE;
		endcase
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			state_r <= TRESET;
		end else if (tck_rise) begin
			state_r <= state_nxt;
		end
	end

	always_comb begin
		ctl.capture = tck_rise && state_r == CAP_DR;
		ctl.shift = tck_rise && state_r == SH_DR;
		ctl.update = tck_rise && state_r == UPD_DR;
		ctl.ir_capture = tck_rise && state_r == CAP_IR;
		ctl.ir_shift = tck_rise && state_r == SH_IR;
		ctl.ir_update = tck_rise && state_r == UPD_IR;
	end
endmodule
`default_nettype wire

// *** tb/scan_host.sv ***
`timescale 1ns/10ps
`default_nettype none
// ============================================================
// External test controller driving the four-wire port.
module scan_host
	import scan_pkg::*;
(
	input wire logic clk_sys,
	input wire logic tdo_r,
	output var tap_pins_s pins
);
	initial pins = '0;

	// One test clock of 16 system clocks; output is read just before rise.
	task automatic step(input logic tms, input logic tdi, output logic tdo);
		pins.tck <= 1'b0;
		pins.tms <= tms;
		pins.tdi <= tdi;
		repeat (8) @(posedge clk_sys);
		tdo = tdo_r;
		pins.tck <= 1'b1;
		repeat (8) @(posedge clk_sys);
	endtask

	// From idle through capture, shift, update and back to idle.
	task automatic walk(input logic ir, input int n, input logic [31:0] din,
		output logic [31:0] dout);
		logic b;
		dout = '0;
		step(1'b1, 1'b0, b);
		if (ir) begin
			step(1'b1, 1'b0, b);
		end
		step(1'b0, 1'b0, b);
		step(1'b0, 1'b0, b);
		for (int i = 0; i < n; i++) begin
			step(i == n - 1, din[i], b);
			dout[i] = b;
		end
		step(1'b1, 1'b0, b);
		step(1'b0, 1'b0, b);
		// The clock rests low between frames and data stops being valid.
		pins.tck <= 1'b0;
		pins.tdi <= ~din[n-1];
		@(posedge clk_sys);
	endtask

	task automatic load_ir(input logic [IR_LEN-1:0] code,
		output logic [IR_LEN-1:0] cap);
		logic [31:0] d;
		walk(1'b1, IR_LEN, {22'h0, code}, d);
		cap = d[IR_LEN-1:0];
	endtask

	task automatic scan_dr(input logic [31:0] din, output logic [31:0] dout);
		walk(1'b0, 32, din, dout);
	endtask

	task automatic reset_tap();
		logic b;
		repeat (5) step(1'b1, 1'b0, b);
		step(1'b0, 1'b0, b);
		pins.tck <= 1'b0;
		@(posedge clk_sys);
	endtask
endmodule
`default_nettype wire

// *** tb/tb_boundary_scan_instruction_unit.sv ***
`timescale 1ns/10ps
`default_nettype none
// ============================================================
// Self-checking bench for the scan unit.
module tb_boundary_scan_instruction_unit
	import scan_pkg::*;
;
	localparam logic [31:0] UCODE = 32'h5A3C96E1;
	logic clk_sys = 1'b0;
	logic resetn = 1'b0;
	logic configured = 1'b0;
	logic configuring = 1'b0;
	logic [7:0] pin_in = '0, core_out = '0, core_oe = '0, keeper_en = '0;
	logic [7:0] p_out, p_oe, p_keep;
	logic tdo, rst_p, abort_p, status_oe, load_p;
	logic tdo_oe;
	logic trst_n = 1'b1;
	logic [7:0] iostd;
	logic [3:0] pll_bits;
	tap_pins_s pins;
	int seed = 32'h61B7289B;
	int n_mismatch = 0;
	int tests_run = 0;
	int n_rst = 0, n_abt = 0, n_ld = 0, n_oe = 0;

	always #2 clk_sys = ~clk_sys;

	scan_unit #(.NPINS(8), .NPLL(4), .USER_CODE(UCODE)) i_dut (
		.clk_sys(clk_sys), .resetn(resetn), .tap_in(pins), .trst_n(trst_n),
		.tdo_r(tdo), .tdo_oe_r(tdo_oe), .pin_in(pin_in), .core_out(core_out),
		.core_oe(core_oe), .keeper_en(keeper_en), .pin_out_r(p_out),
		.pin_oe_r(p_oe), .pin_keep_r(p_keep), .configured(configured),
		.configuring(configuring), .config_restart_r(rst_p),
		.config_abort_r(abort_p), .config_status_oe_r(status_oe),
		.iostd_load_r(load_p), .iostd_r(iostd), .pll_bits_r(pll_bits));

	scan_host i_host (.clk_sys(clk_sys), .tdo_r(tdo), .pins(pins));

	// Pulses are counted so that a stuck request shows as a count above one.
	always @(posedge clk_sys) begin
		n_rst <= n_rst + (rst_p === 1'b1);
		n_abt <= n_abt + (abort_p === 1'b1);
		n_ld <= n_ld + (load_p === 1'b1);
		n_oe <= n_oe + (tdo_oe === 1'b1);
	end

	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	function automatic logic [31:0] id_value();
		return {ID_VERSION, ID_PART, ID_MAKER, ID_LSB};
	endfunction

	function automatic bit assigned(input logic [9:0] c);
		return c inside {OP_EXTEST, OP_RESTART, OP_SAMPLE, OP_IDENT, OP_USER,
			OP_CLAMP, OP_HIGHZ, OP_IOSTD, OP_BYPASS};
	endfunction

	task automatic settle();
		repeat (4) @(posedge clk_sys);
	endtask

	task automatic pins_rand();
		pin_in <= 8'($random(seed));
		core_out <= 8'($random(seed));
		core_oe <= 8'($random(seed));
		keeper_en <= 8'($random(seed));
		@(posedge clk_sys);
	endtask

	task automatic ir(input logic [9:0] code);
		logic [9:0] cap;
		i_host.load_ir(code, cap);
		check("ir_capture", cap, IR_CAPTURE);
	endtask

	task automatic dr(input logic [31:0] din, input logic [31:0] exp,
		input string what);
		logic [31:0] d;
		i_host.scan_dr(din, d);
		check(what, d, exp);
	endtask

	initial begin
		repeat (90000) @(posedge clk_sys);
		n_mismatch++;
		print_verdict();
	end

	initial begin
		logic [31:0] d, e, x;
		logic [9:0] c;
		int k;
		repeat (8) @(posedge clk_sys);
		resetn <= 1'b1;
		repeat (4) @(posedge clk_sys);
		// Scans run with configuration idle, except the first pin-standard load.
		i_host.reset_tap();
		d = $random(seed);
		dr(d, id_value(), "idcode_reset");
		ir(OP_IDENT);
		dr(d, id_value(), "idcode");
		ir(OP_USER);
		k = n_oe;
		dr(d, UCODE, "usercode");
		check("tdo_oe_cycles", n_oe - k, 32 * TCK_CYCLES);
		trst_n <= 1'b0;
		repeat (4) @(posedge clk_sys);
		trst_n <= 1'b1;
		repeat (4) @(posedge clk_sys);
		dr(d, id_value(), "idcode_trst");
		for (int j = 0; j < 6; j++) begin
			c = (j == 0) ? OP_BYPASS : 10'($random(seed));
			if (j == 1 || (j > 1 && assigned(c))) begin
				c = 10'h3FE;
			end
			pins_rand();
			ir(c);
			d = $random(seed);
			dr(d, {d[30:0], 1'b0}, "bypass");
			settle();
			check("normal_out", p_out, core_out);
			check("normal_oe", p_oe, core_oe);
		end
		ir(OP_HIGHZ);
		dr(d, {d[30:0], 1'b0}, "highz_path");
		settle();
		check("highz_oe", p_oe, 8'h00);
		check("highz_keep", p_keep, keeper_en);
		configured <= 1'b1;
		ir(OP_SAMPLE);
		d = $random(seed);
		dr(d, {d[7:0], pin_in, core_out, core_oe}, "sample");
		settle();
		check("sample_out", p_out, core_out);
		ir(OP_EXTEST);
		settle();
		check("preload_out", p_out, d[23:16]);
		check("preload_oe", p_oe, d[15:8]);
		pins_rand();
		x = $random(seed);
		i_host.scan_dr(x, e);
		check("extest_capture", e[23:16], pin_in);
		settle();
		check("extest_out", p_out, x[23:16]);
		check("extest_oe", p_oe, x[15:8]);
		ir(OP_CLAMP);
		d = $random(seed);
		dr(d, {d[30:0], 1'b0}, "clamp_path");
		settle();
		check("clamp_out", p_out, x[23:16]);
		configured <= 1'b0;
		ir(OP_SAMPLE);
		i_host.scan_dr(d, e);
		check("pll_in_chain", e[31:28], d[3:0]);
		check("pll_bits", pll_bits, d[7:4]);
		k = n_rst;
		ir(OP_RESTART);
		settle();
		check("restart_pulses", n_rst - k, 1);
		configuring <= 1'b1;
		k = n_abt;
		e = n_ld;
		ir(OP_IOSTD);
		i_host.scan_dr(d, x);
		settle();
		check("abort_pulses", n_abt - k, 1);
		check("iostd_loaded", n_ld > e, 1);
		check("iostd_value", iostd, d[15:8]);
		check("status_low", status_oe, 1);
		configuring <= 1'b0;
		repeat (50) @(posedge clk_sys);
		check("status_held", status_oe, 1);
		configured <= 1'b1;
		settle();
		check("status_free", status_oe, 0);
		k = n_abt;
		ir(OP_IOSTD);
		settle();
		check("abort_idle", n_abt - k, 0);
		print_verdict();
	end
endmodule
`default_nettype wire
